// [flash_protect_params.svh]
// Constants shared by both ends of the serial flash protection link.
//
// Operation
// - Chip select low means selected, active power.
// - Stay active until internal cycle ends.
// - Power-up delay blocks all modifying instructions.
// - Modifying instruction needs clock count multiple eight.
// - Modifying instruction needs write enable latch set.
// - Latch clears at reset and command completion.
// - Protect bits make upper region read only.
// - Write protect low locks protect bits (here only while lock bit 7 is also set).
// - Codes 000 to 011 protect 0/2/4/8 sectors.
// - Codes 100 to 111 protect 16/32/64/128.
// - Bulk erase only with protect bits zero.
// - Hold pauses link, never aborts internal cycle.
// - Master selects device before asserting hold.
// - Pause starts at hold fall with clock low.
// - Pause ends at hold rise with clock low.
// - Paused device ignores inputs, output floats.
// - Master keeps select low through pause.
// - Deselect during pause resets interface logic.
// - Master releases hold before selecting again.
// - Device keeps status register of status bits.
// - Sample input on rise, drive on fall.
// - Deselected device keeps output floating.
// - Busy status bit set through internal cycles.
`ifndef FLASH_PROTECT_PARAMS_SVH
`define FLASH_PROTECT_PARAMS_SVH

`define SYS_CLK_PERIOD_NS 50
`define LINK_CLK_PERIOD_NS 400
`define POWERUP_WRITE_DELAY_US 10
`define POWERUP_WRITE_DELAY_CYCLES \
  ((`POWERUP_WRITE_DELAY_US * 1000 + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS)
`define SCLK_HALF_CYCLES (`LINK_CLK_PERIOD_NS / 2 / `SYS_CLK_PERIOD_NS)

`define OPC_WRITE_ENABLE 8'h06
`define OPC_WRITE_DISABLE 8'h04
`define OPC_STATUS_READ 8'h05
`define OPC_STATUS_WRITE 8'h01
`define OPC_PAGE_PROGRAM 8'h02
`define OPC_SECTOR_ERASE 8'hd8
`define OPC_BULK_ERASE 8'hc7

`define LEN_WRITE_ENABLE 1
`define LEN_PAGE_PROGRAM_MIN 5
`define LEN_SECTOR_ERASE 4
`define LEN_BULK_ERASE 1
`define LEN_STATUS_WRITE 2
`define LEN_ADDR_LAST 3

`define ST_BIT_BUSY 0
`define ST_BIT_LATCH 1
`define ST_PROT_LSB 2
`define ST_PROT_MSB 4
`define ST_BIT_LOCK 7

`define SECTOR_COUNT 128
`define ADDR_SECTOR_MSB 22
`define ADDR_SECTOR_LSB 16

`define PIN_CS 0
`define PIN_SCLK 1
`define PIN_MOSI 2
`define PIN_HOLD 3
`define PIN_WP 4
`define PIN_IDLE 5'h19

`define REG_CTRL 8'h00
`define REG_DATA 8'h04
`define REG_STATUS 8'h08
`define CTRL_SELECT 0
`define CTRL_HOLD 1
`define CTRL_WP_LOW 2
`define CTRL_CPOL 3
`define STAT_BUSY 0
`define XFER_LAST_STEP 5'd16

`endif

// [flash_protect_pkg.sv]
// Types shared by both ends of the serial flash protection link.
package flash_protect_pkg;
  typedef enum logic [1:0] {KIND_PROGRAM, KIND_SECTOR, KIND_BULK, KIND_STATUS} cycle_kind_e;
  typedef enum logic {XFER_IDLE, XFER_RUN} xfer_state_e;
  typedef logic [7:0]  byte_t;
  typedef logic [23:0] flash_addr_t;
endpackage

// [spi_flash_if.sv]
// Serial flash link between a bus master and the flash device.
`timescale 1ns/1ps
interface spi_flash_if;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic hold_n;
  logic wp_n;
  logic miso;
  logic miso_oe;

  modport flash (
    input  cs_n,
    input  sclk,
    input  mosi,
    input  hold_n,
    input  wp_n,
    output miso,
    output miso_oe
  );

  modport master (
    output cs_n,
    output sclk,
    output mosi,
    output hold_n,
    output wp_n,
    input  miso,
    input  miso_oe
  );
endinterface

// [serial_flash_protect_hold.sv]
// Flash device end: power state, write latch, protection and hold pause.
`timescale 1ns/1ps
`include "flash_protect_params.svh"
module serial_flash_protect_hold
  import flash_protect_pkg::*;
#(
  parameter int unsigned POWERUP_CYCLES = `POWERUP_WRITE_DELAY_CYCLES
) (
  input  wire logic  sys_clk,
  input  wire logic  rst_n,
  spi_flash_if.flash spi,
  input  wire logic  cycle_done,
  output logic       cycle_start,
  output cycle_kind_e cycle_kind,
  output flash_addr_t cycle_addr,
  output logic       active_power,
  output logic       write_in_progress,
  output logic       write_enable_latch,
  output logic [2:0] protect_level,
  output logic       status_write_disable,
  output logic       software_protection_state,
  output logic       hardware_protection_state,
  output logic       paused
);

  // ****************************************************************
  // Pin synchronisers and edge detection
  // ****************************************************************
  logic [4:0] pins;
  logic [4:0] meta_q;
  logic [4:0] sync_q;
  logic [4:0] prev_q;

  assign pins = {spi.wp_n, spi.hold_n, spi.mosi, spi.sclk, spi.cs_n};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= `PIN_IDLE;
      sync_q <= `PIN_IDLE;
      prev_q <= `PIN_IDLE;
    end else begin
      meta_q <= pins;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  wire cs_s      = sync_q[`PIN_CS];
  wire sclk_s    = sync_q[`PIN_SCLK];
  wire mosi_s    = sync_q[`PIN_MOSI];
  wire hold_s    = sync_q[`PIN_HOLD];
  wire wp_s      = sync_q[`PIN_WP];
  wire selected  = ~cs_s;
  wire cs_fall   = prev_q[`PIN_CS] & ~cs_s;
  wire cs_rise   = ~prev_q[`PIN_CS] & cs_s;
  wire sclk_rise = ~prev_q[`PIN_SCLK] & sclk_s;
  wire sclk_fall = prev_q[`PIN_SCLK] & ~sclk_s;
  wire hold_fall = prev_q[`PIN_HOLD] & ~hold_s;

  // ****************************************************************
  // Hold pause
  // ****************************************************************
  // Entry is armed by the falling edge of hold only, so a hold that is
  // still low when the device is selected again cannot pause it.
  logic pend_q;
  logic paused_q;
  logic paused_d;
  logic pend_d;

  wire enter_req = selected & ~hold_s & (pend_q | hold_fall);
  always_comb begin
    if (cs_rise) begin
      paused_d = 1'b0;
    end else if (paused_q) begin
      paused_d = ~(hold_s & ~sclk_s);
    end else begin
      paused_d = enter_req & ~sclk_s;
    end
    pend_d = ~cs_rise & ~paused_d & enter_req;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      paused_q <= 1'b0;
      pend_q   <= 1'b0;
    end else begin
      paused_q <= paused_d;
      pend_q   <= pend_d;
    end
  end

  wire link_on = selected & ~paused_q;
  wire rise_ok = sclk_rise & link_on;
  wire fall_ok = sclk_fall & link_on;

  // ****************************************************************
  // Instruction framing
  // ****************************************************************
  logic [2:0]  bit_cnt_q;
  logic [2:0]  byte_cnt_q;
  byte_t       in_sh_q;
  byte_t       opcode_q;
  byte_t       stat_data_q;
  flash_addr_t addr_q;

  wire byte_t in_full  = {in_sh_q[6:0], mosi_s};
  wire        byte_end = rise_ok & (bit_cnt_q == 3'd7);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_q  <= '0;
      byte_cnt_q <= '0;
      in_sh_q    <= '0;
      opcode_q   <= '0;
    end else if (cs_fall | cs_rise) begin
      bit_cnt_q  <= '0;
      byte_cnt_q <= '0;
      opcode_q   <= '0;
    end else if (rise_ok) begin
      in_sh_q   <= in_full;
      bit_cnt_q <= 3'(bit_cnt_q + 3'd1);
      if (bit_cnt_q == 3'd7 && byte_cnt_q != 3'd7) begin
        byte_cnt_q <= 3'(byte_cnt_q + 3'd1);
      end
      if (byte_end && byte_cnt_q == 3'd0) begin
        opcode_q <= in_full;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_q      <= '0;
      stat_data_q <= '0;
    end else if (byte_end) begin
      if (byte_cnt_q != 3'd0 && byte_cnt_q <= 3'(`LEN_ADDR_LAST)) begin
        addr_q <= {addr_q[15:0], in_full};
      end
      if (byte_cnt_q == 3'd1) begin
        stat_data_q <= in_full;
      end
    end
  end

  // ****************************************************************
  // Protection checks
  // ****************************************************************
  function automatic logic sector_locked(input logic [2:0] level, input flash_addr_t a);
    logic [7:0] first;
    first = (level == 3'd0) ? 8'(`SECTOR_COUNT)
                            : 8'(8'(`SECTOR_COUNT) - (8'h01 << level));
    return {1'b0, a[`ADDR_SECTOR_MSB:`ADDR_SECTOR_LSB]} >= first;
  endfunction

  logic        busy_q;
  logic        latch_q;
  logic        lock_q;
  logic [2:0]  prot_q;
  logic [15:0] powerup_cnt_q;

  wire powerup_busy = powerup_cnt_q != 16'(POWERUP_CYCLES);
  wire hw_lock      = lock_q & ~wp_s;
  wire end_cmd      = cs_rise & ~paused_q;
  wire aligned      = bit_cnt_q == 3'd0;
  wire write_ready  = aligned & latch_q & ~powerup_busy & ~busy_q;

  wire is_prog  = (opcode_q == `OPC_PAGE_PROGRAM) &
                  (byte_cnt_q >= 3'(`LEN_PAGE_PROGRAM_MIN));
  wire is_erase = (opcode_q == `OPC_SECTOR_ERASE) &
                  (byte_cnt_q == 3'(`LEN_SECTOR_ERASE));
  wire is_bulk  = (opcode_q == `OPC_BULK_ERASE) &
                  (byte_cnt_q == 3'(`LEN_BULK_ERASE));
  wire is_stat  = (opcode_q == `OPC_STATUS_WRITE) &
                  (byte_cnt_q == 3'(`LEN_STATUS_WRITE));
  wire is_write_enable_cmd  = (opcode_q == `OPC_WRITE_ENABLE) &
                  (byte_cnt_q == 3'(`LEN_WRITE_ENABLE)) & aligned;
  wire is_write_disable_cmd  = (opcode_q == `OPC_WRITE_DISABLE) & aligned & ~busy_q;

  wire prog_go  = is_prog & ~sector_locked(prot_q, addr_q);
  wire erase_go = is_erase & ~sector_locked(prot_q, addr_q);
  wire bulk_go  = is_bulk & (prot_q == 3'd0);
  wire stat_go  = is_stat & ~hw_lock;
  wire start    = end_cmd & write_ready & (prog_go | erase_go | bulk_go | stat_go);
  wire finish   = busy_q & cycle_done;

  // ****************************************************************
  // Status bits and internal cycle
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      powerup_cnt_q <= '0;
    end else if (powerup_busy) begin
      powerup_cnt_q <= 16'(powerup_cnt_q + 16'd1);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_q <= 1'b0;
    end else if (end_cmd & is_write_enable_cmd & ~busy_q) begin
      latch_q <= 1'b1;
    end else if ((end_cmd & is_write_disable_cmd) | finish) begin
      latch_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
    end else if (start) begin
      busy_q <= 1'b1;
    end else if (finish) begin
      busy_q <= 1'b0;
    end
  end

  // Protect bits stay volatile here; keeping them across power cycles is
  // the array's job.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prot_q <= '0;
      lock_q <= 1'b0;
    end else if (start & is_stat) begin
      prot_q <= stat_data_q[`ST_PROT_MSB:`ST_PROT_LSB];
      lock_q <= stat_data_q[`ST_BIT_LOCK];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cycle_start <= 1'b0;
      cycle_kind  <= KIND_PROGRAM;
      cycle_addr  <= '0;
    end else begin
      cycle_start <= start;
      if (start) begin
        cycle_addr <= addr_q;
        cycle_kind <= is_prog ? KIND_PROGRAM : is_erase ? KIND_SECTOR :
                      is_bulk ? KIND_BULK : KIND_STATUS;
      end
    end
  end

  byte_t status_byte;
  always_comb begin
    status_byte = '0;
    status_byte[`ST_BIT_BUSY] = busy_q;
    status_byte[`ST_BIT_LATCH] = latch_q;
    status_byte[`ST_PROT_MSB:`ST_PROT_LSB] = prot_q;
    status_byte[`ST_BIT_LOCK] = lock_q;
  end

  // ****************************************************************
  // Status read output
  // ****************************************************************
  // The status byte is reloaded after every eighth bit so that a
  // polling master sees the busy bit fall without a new instruction.
  logic       read_q;
  logic       miso_q;
  byte_t      out_sh_q;
  logic [2:0] out_cnt_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      read_q    <= 1'b0;
      miso_q    <= 1'b0;
      out_sh_q  <= '0;
      out_cnt_q <= '0;
    end else if (cs_fall | cs_rise) begin
      read_q <= 1'b0;
    end else if (byte_end && byte_cnt_q == 3'd0 && in_full == `OPC_STATUS_READ) begin
      read_q    <= 1'b1;
      out_sh_q  <= status_byte;
      out_cnt_q <= '0;
    end else if (fall_ok & read_q) begin
      miso_q    <= out_sh_q[7];
      out_sh_q  <= (out_cnt_q == 3'd7) ? status_byte : {out_sh_q[6:0], 1'b0};
      out_cnt_q <= 3'(out_cnt_q + 3'd1);
    end
  end

  assign spi.miso    = miso_q;
  assign spi.miso_oe = link_on & read_q;

  assign active_power              = selected | busy_q;
  assign write_in_progress         = busy_q;
  assign write_enable_latch        = latch_q;
  assign protect_level             = prot_q;
  assign status_write_disable      = lock_q;
  assign software_protection_state = prot_q != 3'd0;
  assign hardware_protection_state = hw_lock;
  assign paused                    = paused_q;

endmodule // serial_flash_protect_hold

// [flash_spi_master.sv]
// Bus master end: AHB-Lite registers driving the serial flash link.
`timescale 1ns/1ps
`include "flash_protect_params.svh"
module flash_spi_master
  import flash_protect_pkg::*;
#(
  parameter int unsigned HALF_CYCLES = `SCLK_HALF_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  spi_flash_if.master      spi
);

  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************
  logic [3:0]  ctrl_q;
  logic        wr_q;
  logic [7:0]  waddr_q;
  logic [31:0] rdata_d;
  byte_t       rx_q;
  xfer_state_e state_q;

  wire take = hsel & hready & htrans[1];
  wire busy = state_q == XFER_RUN;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_comb begin
    rdata_d = '0;
    unique case (haddr)
      `REG_CTRL:   rdata_d[3:0] = ctrl_q;
      `REG_DATA:   rdata_d[7:0] = rx_q;
      `REG_STATUS: rdata_d[`STAT_BUSY] = busy;
      default:     rdata_d = '0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q    <= 1'b0;
      waddr_q <= '0;
      hrdata  <= '0;
    end else begin
      wr_q    <= take & hwrite;
      waddr_q <= haddr;
      if (take & ~hwrite) begin
        hrdata <= rdata_d;
      end
    end
  end

  wire wr_ctrl = wr_q & (waddr_q == `REG_CTRL);
  wire wr_data = wr_q & (waddr_q == `REG_DATA) & ~busy;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= '0;
    end else if (wr_ctrl) begin
      ctrl_q <= hwdata[3:0];
    end
  end

  // ****************************************************************
  // Byte engine
  // ****************************************************************
  logic       meta_q;
  logic       miso_s;
  logic [7:0] div_q;
  logic [4:0] step_q;
  logic [3:0] rises_q;
  logic       pend_q;
  logic       sclk_q;
  byte_t      tx_q;
  byte_t      rx_sh_q;

  wire cpol     = ctrl_q[`CTRL_CPOL];
  wire hold_on  = ctrl_q[`CTRL_HOLD];
  // Hold freezes the clock only once it is low, so the device pause can
  // begin at once rather than wait for a falling edge that never comes.
  wire tick     = busy & (div_q == 8'(HALF_CYCLES - 1)) & ~(hold_on & ~sclk_q);
  wire last     = step_q == `XFER_LAST_STEP;
  wire falling  = sclk_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      miso_s <= 1'b0;
    end else begin
      meta_q <= spi.miso;
      miso_s <= meta_q;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= '0;
    end else if (~busy | tick) begin
      div_q <= '0;
    end else if (div_q != 8'(HALF_CYCLES - 1)) begin
      div_q <= 8'(div_q + 8'd1);
    end
  end

  // Reads sample one half period after the rising edge, which leaves the
  // device's synchronised output path time to settle.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= XFER_IDLE;
      step_q  <= '0;
      rises_q <= '0;
      pend_q  <= 1'b0;
      sclk_q  <= 1'b0;
      tx_q    <= '0;
      rx_sh_q <= '0;
      rx_q    <= '0;
    end else if (wr_data) begin
      state_q <= XFER_RUN;
      tx_q    <= hwdata[7:0];
      step_q  <= '0;
      rises_q <= '0;
      pend_q  <= 1'b0;
    end else if (~busy) begin
      sclk_q <= cpol;
    end else if (tick) begin
      step_q <= 5'(step_q + 5'd1);
      pend_q <= ~last & ~sclk_q;
      if (pend_q) begin
        rx_sh_q <= {rx_sh_q[6:0], miso_s};
      end
      if (last) begin
        state_q <= XFER_IDLE;
        rx_q    <= pend_q ? {rx_sh_q[6:0], miso_s} : rx_sh_q;
      end else begin
        sclk_q <= ~sclk_q;
        if (~sclk_q) begin
          rises_q <= 4'(rises_q + 4'd1);
        end else if (falling && rises_q != 4'd0 && rises_q != 4'd8) begin
          tx_q <= {tx_q[6:0], 1'b0};
        end
      end
    end
  end

  assign spi.sclk   = sclk_q;
  assign spi.mosi   = tx_q[7];
  assign spi.cs_n   = ~ctrl_q[`CTRL_SELECT];
  assign spi.hold_n = ~hold_on;
  assign spi.wp_n   = ~ctrl_q[`CTRL_WP_LOW];

endmodule // flash_spi_master

// [flash_link_monitor.sv]
// Checker that watches the serial flash link and the device status outputs.
`timescale 1ns/1ps
module flash_link_monitor
  import flash_protect_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        cs_n,
  input wire logic        hold_n,
  input wire logic        miso_oe,
  input wire logic        cycle_done,
  input wire logic        cycle_start,
  input wire cycle_kind_e cycle_kind,
  input wire logic        active_power,
  input wire logic        write_in_progress,
  input wire logic        write_enable_latch,
  input wire logic [2:0]  protect_level,
  input wire logic        status_write_disable,
  input wire logic        hardware_protection_state,
  input wire logic        paused
);
  // ****************************************
  // Link and status properties.
  // ****************************************
  // Five samples of a pin cover the two-flop synchroniser plus the register after it.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_select_active;
    (!cs_n) [*5] |-> active_power;
  endproperty
  a_select_active: assert property (p_select_active) else $error("selected but idle");

  property p_standby;
    cs_n [*5] ##0 !write_in_progress |-> !active_power;
  endproperty
  a_standby: assert property (p_standby) else $error("no standby when free");

  property p_busy_active;
    write_in_progress |-> active_power;
  endproperty
  a_busy_active: assert property (p_busy_active) else $error("standby while busy");

  property p_float_deselect;
    cs_n [*5] |-> !miso_oe;
  endproperty
  a_float_deselect: assert property (p_float_deselect) else $error("driven deselected");

  property p_float_paused;
    paused ##1 paused |-> !miso_oe;
  endproperty
  a_float_paused: assert property (p_float_paused) else $error("driven while paused");

  property p_start_needs_latch;
    cycle_start |-> $past(write_enable_latch);
  endproperty
  a_start_needs_latch: assert property (p_start_needs_latch) else $error("start no latch");

  property p_start_busy;
    cycle_start |-> ##[0:1] write_in_progress;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("start without busy");

  property p_done_clears;
    write_in_progress && cycle_done |=> !write_in_progress && !write_enable_latch;
  endproperty
  a_done_clears: assert property (p_done_clears) else $error("done left state");

  property p_busy_holds;
    write_in_progress && !cycle_done |=> write_in_progress;
  endproperty
  a_busy_holds: assert property (p_busy_holds) else $error("busy dropped early");

  property p_bulk_unprotected;
    cycle_start && cycle_kind == KIND_BULK |-> protect_level == 3'h0;
  endproperty
  a_bulk_unprotected: assert property (p_bulk_unprotected) else $error("bulk protected");

  property p_hw_lock;
    hardware_protection_state |=> $stable(protect_level) && $stable(status_write_disable);
  endproperty
  a_hw_lock: assert property (p_hw_lock) else $error("locked bits changed");

  property p_pause_entry;
    $rose(paused) |-> !cs_n && !hold_n;
  endproperty
  a_pause_entry: assert property (p_pause_entry) else $error("pause without cause");
endmodule // flash_link_monitor

// [serial_flash_protect_hold_tb_top.sv]
// Testbench joining the bus master end and the flash device end.
`timescale 1ns/1ps
module serial_flash_protect_hold_tb_top
  import flash_protect_pkg::*;
;
  // ****************************************
  // Signals, instances and helpers.
  // ****************************************
  typedef struct {logic [2:0] code; logic [6:0] sector; logic ok;} row_s;
  localparam int PWR = 400;
  logic sys_clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, cycle_done = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, hrdata, rd;
  logic hreadyout, hresp, cycle_start, active_power, write_in_progress, write_enable_latch;
  logic status_write_disable, software_protection_state, hardware_protection_state, paused;
  logic [2:0] protect_level;
  cycle_kind_e cycle_kind, last_kind;
  flash_addr_t cycle_addr, last_addr;
  logic [3:0] ctl = 4'h0;
  int error_cnt = 0, checks = 0, cyc = 0, starts = 0, n0 = 0;
  row_s rows[14] = '{'{3'h0, 7'd127, 1'b1}, '{3'h1, 7'd125, 1'b1}, '{3'h1, 7'd126, 1'b0},
    '{3'h2, 7'd123, 1'b1}, '{3'h2, 7'd124, 1'b0}, '{3'h3, 7'd119, 1'b1},
    '{3'h3, 7'd120, 1'b0}, '{3'h4, 7'd111, 1'b1}, '{3'h4, 7'd112, 1'b0},
    '{3'h5, 7'd95, 1'b1}, '{3'h5, 7'd96, 1'b0}, '{3'h6, 7'd63, 1'b1},
    '{3'h6, 7'd64, 1'b0}, '{3'h7, 7'd0, 1'b0}};

  spi_flash_if lnk();
  flash_spi_master #(.HALF_CYCLES(4)) flash_spi_master_i (.sys_clk, .rst_n, .hsel, .haddr,
    .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata,
    .hresp, .spi(lnk));
  serial_flash_protect_hold #(.POWERUP_CYCLES(PWR)) serial_flash_protect_hold_i (.sys_clk,
    .rst_n, .spi(lnk), .cycle_done, .cycle_start, .cycle_kind, .cycle_addr, .active_power,
    .write_in_progress, .write_enable_latch, .protect_level, .status_write_disable,
    .software_protection_state, .hardware_protection_state, .paused);
  flash_link_monitor flash_link_monitor_i (.sys_clk, .rst_n, .cs_n(lnk.cs_n),
    .hold_n(lnk.hold_n), .miso_oe(lnk.miso_oe), .cycle_done, .cycle_start, .cycle_kind,
    .active_power, .write_in_progress, .write_enable_latch, .protect_level,
    .status_write_disable, .hardware_protection_state, .paused);

  always #25 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    if (cycle_start === 1'b1) begin
      starts <= starts + 1;
      last_kind <= cycle_kind;
      last_addr <= cycle_addr;
    end
  end

  task automatic print_verdict();
    if (error_cnt == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // The ceiling leaves about four and a half times the expected run length.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      error_cnt++;
      print_verdict();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic set_ctl(input logic [3:0] v);
    ctl = v;
    bus(8'h00, 1'b1, {28'h0, v});
  endtask

  task automatic wait_idle();
    do bus(8'h08, 1'b0, 32'h0); while (rd[0] !== 1'b0);
  endtask

  task automatic xfer(input byte_t b);
    bus(8'h04, 1'b1, {24'h0, b});
    wait_idle();
    bus(8'h04, 1'b0, 32'h0);
  endtask

  task automatic cmd(input int n, input logic [31:0] w);
    set_ctl(ctl | 4'h1);
    for (int i = 0; i < n; i++) xfer(w[31 - 8 * i -: 8]);
    set_ctl(ctl & 4'he);
    repeat (8) @(posedge sys_clk);
  endtask

  task automatic pulse_done();
    @(posedge sys_clk);
    cycle_done <= 1'b1;
    @(posedge sys_clk);
    cycle_done <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask

  task automatic op(input int n, input logic [31:0] w, input logic ok);
    n0 = starts;
    cmd(n, w);
    check(starts - n0, {31'h0, ok});
    check(write_in_progress, ok);
    if (ok) begin
      pulse_done();
      check({write_in_progress, write_enable_latch}, 2'h0);
    end
  endtask

  // ****************************************
  // Main sequence.
  // ****************************************
  initial begin
    repeat (16) @(posedge sys_clk);
    check({lnk.cs_n, lnk.hold_n, lnk.wp_n, lnk.miso_oe, write_enable_latch, paused}, 6'h38);
    rst_n <= 1'b1;
    cmd(1, 32'h06000000);
    op(1, 32'hc7000000, 1'b0);
    repeat (PWR) @(posedge sys_clk);
    cmd(1, 32'h06000000);
    check(write_enable_latch, 1'b1);
    op(1, 32'hc7000000, 1'b1);
    check(last_kind, KIND_BULK);
    op(4, 32'hd8050000, 1'b0);
    cmd(1, 32'h06000000);
    cmd(1, 32'h04000000);
    check(write_enable_latch, 1'b0);
    // A byte cut short by deselection leaves a clock count off the byte grid.
    cmd(1, 32'h06000000);
    n0 = starts;
    set_ctl(4'h1);
    xfer(8'hc7);
    bus(8'h04, 1'b1, 32'h0);
    repeat (12) @(posedge sys_clk);
    set_ctl(4'h0);
    wait_idle();
    repeat (8) @(posedge sys_clk);
    check(starts - n0, 0);
    check(write_enable_latch, 1'b1);
    foreach (rows[i]) begin
      cmd(1, 32'h06000000);
      op(2, {8'h01, 3'h0, rows[i].code, 18'h0}, 1'b1);
      check(protect_level, rows[i].code);
      check(software_protection_state, rows[i].code != 3'h0);
      cmd(1, 32'h06000000);
      op(4, {8'hd8, 1'b0, rows[i].sector, 16'h0}, rows[i].ok);
      if (rows[i].ok) check(last_addr, {1'b0, rows[i].sector, 16'h0});
      if (rows[i].ok) check(last_kind, KIND_SECTOR);
    end
    op(1, 32'hc7000000, 1'b0);
    op(2, 32'h01000000, 1'b1);
    cmd(1, 32'h06000000);
    op(2, 32'h01800000, 1'b1);
    set_ctl(4'h4);
    repeat (4) @(posedge sys_clk);
    check({status_write_disable, hardware_protection_state}, 2'h3);
    cmd(1, 32'h06000000);
    op(2, 32'h011c0000, 1'b0);
    check(protect_level, 3'h0);
    set_ctl(4'h0);
    cmd(1, 32'h06000000);
    op(2, 32'h01000000, 1'b1);
    // Pause a status read while a sector erase is running.
    cmd(1, 32'h06000000);
    cmd(4, 32'hd8030000);
    set_ctl(4'h1);
    xfer(8'h05);
    set_ctl(4'h3);
    repeat (6) @(posedge sys_clk);
    check({paused, lnk.miso_oe}, 2'h2);
    bus(8'h04, 1'b1, 32'h0);
    repeat (40) @(posedge sys_clk);
    check(write_in_progress, 1'b1);
    set_ctl(4'h1);
    repeat (6) @(posedge sys_clk);
    check(paused, 1'b0);
    wait_idle();
    bus(8'h04, 1'b0, 32'h0);
    check(rd[7:0], 8'h03);
    set_ctl(4'h0);
    pulse_done();
    set_ctl(4'h1);
    xfer(8'h06);
    set_ctl(4'h3);
    repeat (6) @(posedge sys_clk);
    check(paused, 1'b1);
    set_ctl(4'h2);
    repeat (6) @(posedge sys_clk);
    check(paused, 1'b0);
    set_ctl(4'h0);
    repeat (4) @(posedge sys_clk);
    check(write_enable_latch, 1'b0);
    cmd(1, 32'h06000000);
    check(write_enable_latch, 1'b1);
    // Idle-high clock: a status read must still shift out busy clear, latch set.
    set_ctl(4'h8);
    cmd(2, 32'h05000000);
    check(rd[7:0], 8'h02);
    set_ctl(4'h0);
    bus(8'h0c, 1'b1, 32'hffffffff);
    bus(8'h0c, 1'b0, 32'h0);
    check(rd, 32'h0);
    check(hresp, 1'b0);
    print_verdict();
  end
endmodule // serial_flash_protect_hold_tb_top
